// file: verilog/priority_crossbar_pin_assigner.v
// priority crossbar: registers, pin allocation, pad drive and input routing
`timescale 1ns/1ns
`include "crossbar_consts.vh"

module priority_crossbar_pin_assigner (
    input  wire                    clk_in,            // 50 MHz system clock
    input  wire                    srst_in,           // synchronous reset, active high
    input  wire [7:0]              sfr_addr_in,       // register address
    input  wire [7:0]              sfr_wdata_in,      // write data
    input  wire                    sfr_wr_in,         // write strobe, one cycle
    input  wire                    sfr_rd_in,         // read strobe, one cycle
    output reg  [7:0]              sfr_rdata_out,     // read data, next cycle
    input  wire [1:0]              spi_select_mode_field_in, // first spi select mode
    input  wire [1:0]              second_spi_mode_in,       // second spi select mode
    input  wire [`NUM_PINS-1:0]    pin_output_drive_type_in, // 1 push-pull, 0 open-drain
    input  wire [`NUM_PINS-1:0]    port_latch_in,     // gpio output latch values
    input  wire [`NUM_FUNCS-1:0]   periph_out_in,     // peripheral output values by code
    input  wire [`NUM_FUNCS-1:0]   periph_drive_in,   // peripheral wants to drive
    input  wire [`NUM_PINS-1:0]    pad_in,            // pad levels, asynchronous
    output reg  [`NUM_PINS-1:0]    pad_out,           // pad output values
    output reg  [`NUM_PINS-1:0]    pad_oe_out,        // pad driver enables
    output reg  [`NUM_PINS-1:0]    pin_level_out,     // synced levels for event capture
    output reg  [`NUM_FUNCS-1:0]   periph_in_out      // pin levels routed to peripherals
);

    // software registers
    reg  [7:0]                     crossbar_select_0;  // function selects
    reg                            second_spi_route;   // select_1 bit 6
    reg                            crossbar_on;        // select_2 bit 6
    reg                            weak_pull_off;      // select_2 bit 7, stored only
    reg  [7:0]                     port0_skip_bits;    // skip bits P0.0-P0.7
    reg  [6:0]                     port1_skip_bits;    // skip bits P1.0-P1.6

    // pad synchroniser stages
    reg  [`NUM_PINS-1:0]           pad_meta;           // first stage, read by second only
    reg  [`NUM_PINS-1:0]           pad_sync;           // second stage

    // allocation results
    wire [`NUM_PINS*`FUNC_W-1:0]   pin_func;           // code per pin
    reg  [`NUM_FUNCS-1:0]          req;                // requested functions
    reg  [`NUM_PINS-1:0]           claimed;            // pins carrying a function
    reg  [`NUM_PINS-1:0]           next_pad;           // next pad values
    reg  [`NUM_PINS-1:0]           next_oe;            // next pad enables
    reg  [`NUM_FUNCS-1:0]          next_periph_in;     // next peripheral inputs
    reg  [7:0]                     next_rdata;         // next read data
    reg  [`FUNC_W-1:0]             code;               // code of current pin
    reg                            val;                // value wanted on current pin
    reg                            drv;                // pin wants to drive
    reg                            push;               // push-pull in effect
    integer                        i;                  // pin loop index

    // select mode 00 is 3-wire, anything else uses the select pin
    function is_four_wire;
        input [1:0] mode;
        begin
            is_four_wire = (mode != 2'b00);
        end
    endfunction

    // register writes; unmapped and read-only addresses ignore writes
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            crossbar_select_0 <= `RESET_BYTE;
            second_spi_route  <= 1'b0;
            crossbar_on       <= 1'b0;
            weak_pull_off     <= 1'b0;
            port0_skip_bits   <= `RESET_BYTE;
            port1_skip_bits   <= 7'h00;
        end
        else if (sfr_wr_in)
        begin
            if (sfr_addr_in == `ADDR_SELECT_0)
                crossbar_select_0 <= sfr_wdata_in;
            else if (sfr_addr_in == `ADDR_SELECT_1)
                second_spi_route <= sfr_wdata_in[`BIT_SECOND_SPI];
            else if (sfr_addr_in == `ADDR_SELECT_2)
            begin
                crossbar_on   <= sfr_wdata_in[`BIT_CROSSBAR_ON];
                weak_pull_off <= sfr_wdata_in[`BIT_WEAK_PULL_OFF];
            end
            else if (sfr_addr_in == `ADDR_PORT0_SKIP)
                port0_skip_bits <= sfr_wdata_in;
            else if (sfr_addr_in == `ADDR_PORT1_SKIP)
                port1_skip_bits <= sfr_wdata_in[6:0];
        end
    end

    // read mux; unused bits and unmapped addresses read zero
    always @*
    begin
        next_rdata = 8'h00;
        if (sfr_addr_in == `ADDR_SELECT_0)
            next_rdata = crossbar_select_0;
        else if (sfr_addr_in == `ADDR_SELECT_1)
            next_rdata[`BIT_SECOND_SPI] = second_spi_route;
        else if (sfr_addr_in == `ADDR_SELECT_2)
        begin
            next_rdata[`BIT_CROSSBAR_ON]   = crossbar_on;
            next_rdata[`BIT_WEAK_PULL_OFF] = weak_pull_off;
        end
        else if (sfr_addr_in == `ADDR_PORT0_SKIP)
            next_rdata = port0_skip_bits;
        else if (sfr_addr_in == `ADDR_PORT1_SKIP)
            next_rdata = {1'b0, port1_skip_bits};
        else if (sfr_addr_in == `ADDR_CLAIMED_P0)
            next_rdata = claimed[7:0];
        else if (sfr_addr_in == `ADDR_CLAIMED_P1)
            next_rdata = {1'b0, claimed[14:8]};
    end

    // read data register, held between reads
    always @(posedge clk_in)
    begin
        if (srst_in)
            sfr_rdata_out <= `RESET_BYTE;
        else if (sfr_rd_in)
            sfr_rdata_out <= next_rdata;
    end

    // pad synchroniser; pads are outside the clock domain
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pad_meta <= {`NUM_PINS{1'b0}};
            pad_sync <= {`NUM_PINS{1'b0}};
        end
        else
        begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    // request vector from the select registers
    always @*
    begin
        req = {`NUM_FUNCS{1'b0}};
        req[`FN_SER_TX] = crossbar_select_0[`BIT_SERIAL_PORT];
        req[`FN_SER_RX] = crossbar_select_0[`BIT_SERIAL_PORT];
        // second spi clock, miso, mosi and its select in 4-wire
        req[`FN_SECOND_SPI_PORT_SCK + 0] = second_spi_route;
        req[`FN_SECOND_SPI_PORT_SCK + 1] = second_spi_route;
        req[`FN_SECOND_SPI_PORT_SCK + 2] = second_spi_route;
        req[`FN_SECOND_SPI_PORT_NSS] = second_spi_route & is_four_wire(second_spi_mode_in);
        req[`FN_FIRST_SPI_PORT_SCK]  = crossbar_select_0[`BIT_FIRST_SPI];
        req[`FN_FIRST_SPI_PORT_MISO] = crossbar_select_0[`BIT_FIRST_SPI];
        req[`FN_FIRST_SPI_PORT_MOSI] = crossbar_select_0[`BIT_FIRST_SPI];
        req[`FN_FIRST_SPI_PORT_NSS] = crossbar_select_0[`BIT_FIRST_SPI]
                          & is_four_wire(spi_select_mode_field_in);
        req[`FN_TW_SDA] = crossbar_select_0[`BIT_TWO_WIRE];
        req[`FN_TW_SCL] = crossbar_select_0[`BIT_TWO_WIRE];
        req[`FN_CMP0_OUT]   = crossbar_select_0[`BIT_CMP0_OUT];
        req[`FN_CMP0_ASYNC] = crossbar_select_0[`BIT_CMP0_ASYNC];
        req[`FN_CMP1_OUT]   = crossbar_select_0[`BIT_CMP1_OUT];
        req[`FN_CMP1_ASYNC] = crossbar_select_0[`BIT_CMP1_ASYNC];
        req[`FN_SYS_CLOCK] = crossbar_select_0[`BIT_SYS_CLOCK];
    end

    crossbar_alloc u_alloc (
        .req_in       (req),
        .skip_in      ({port1_skip_bits, port0_skip_bits}),
        .pin_func_out (pin_func)
    );

    // per-pin drive and peripheral input routing
    always @*
    begin
        claimed        = {`NUM_PINS{1'b0}};
        next_pad       = {`NUM_PINS{1'b1}};
        next_oe        = {`NUM_PINS{1'b0}};
        // unrouted peripheral inputs idle high
        next_periph_in = {`NUM_FUNCS{1'b1}};
        code           = `FN_NONE;
        val            = 1'b1;
        drv            = 1'b0;
        push           = 1'b0;
        for (i = 0; i < `NUM_PINS; i = i + 1)
        begin
            code = pin_func[i*`FUNC_W +: `FUNC_W];
            if (code != `FN_NONE)
            begin
                // claimed pin follows its peripheral
                claimed[i] = 1'b1;
                val  = periph_out_in[code];
                drv  = periph_drive_in[code];
                push = pin_output_drive_type_in[i]
                     & (code != `FN_TW_SDA) & (code != `FN_TW_SCL);
                next_periph_in[code] = pad_sync[i];
            end
            else
            begin
                // gpio pin follows its latch
                val  = port_latch_in[i];
                drv  = 1'b1;
                push = pin_output_drive_type_in[i];
            end
            next_pad[i] = val;
            next_oe[i] = crossbar_on & drv & (push | ~val);
        end
    end

    // registered pad, peripheral and event outputs
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pad_out       <= {`NUM_PINS{1'b1}};
            pad_oe_out    <= {`NUM_PINS{1'b0}};
            pin_level_out <= {`NUM_PINS{1'b0}};
            periph_in_out <= {`NUM_FUNCS{1'b1}};
        end
        else
        begin
            pad_out       <= next_pad;
            pad_oe_out    <= next_oe;
            // levels of all pins, claimed or not
            pin_level_out <= pad_sync;
            periph_in_out <= next_periph_in;
        end
    end

endmodule // priority_crossbar_pin_assigner

// file: common/crossbar_consts.vh
// constants for the priority crossbar pin assigner
`ifndef CROSSBAR_CONSTS_VH
`define CROSSBAR_CONSTS_VH

// register addresses on the special-function-register bus
`define ADDR_SELECT_0       8'hE1
`define ADDR_SELECT_1       8'hE2
`define ADDR_SELECT_2       8'hE3
`define ADDR_PORT0_SKIP     8'hD4
`define ADDR_PORT1_SKIP     8'hD5
`define ADDR_CLAIMED_P0     8'hD6
`define ADDR_CLAIMED_P1     8'hD7

// reset values
`define RESET_BYTE          8'h00

// crossbar_select_0 fields
`define BIT_CMP1_ASYNC      7
`define BIT_CMP1_OUT        6
`define BIT_CMP0_ASYNC      5
`define BIT_CMP0_OUT        4
`define BIT_SYS_CLOCK       3
`define BIT_TWO_WIRE        2
`define BIT_FIRST_SPI       1
`define BIT_SERIAL_PORT     0
// crossbar_select_1 and crossbar_select_2 fields
`define BIT_SECOND_SPI      6
`define BIT_CROSSBAR_ON     6
`define BIT_WEAK_PULL_OFF   7

// pin and function counts
`define NUM_PINS            15
`define NUM_FUNCS           18
`define FUNC_W              5

// function codes, ascending code is descending priority
`define FN_NONE             5'h00
`define FN_SER_TX           5'h01
`define FN_SER_RX           5'h02
`define FN_SECOND_SPI_PORT_SCK         5'h03
`define FN_SECOND_SPI_PORT_NSS         5'h06
`define FN_FIRST_SPI_PORT_SCK         5'h07
`define FN_FIRST_SPI_PORT_MISO        5'h08
`define FN_FIRST_SPI_PORT_MOSI        5'h09
`define FN_FIRST_SPI_PORT_NSS         5'h0A
`define FN_TW_SDA           5'h0B
`define FN_TW_SCL           5'h0C
`define FN_CMP0_OUT         5'h0D
`define FN_CMP0_ASYNC       5'h0E
`define FN_CMP1_OUT         5'h0F
`define FN_CMP1_ASYNC       5'h10
`define FN_SYS_CLOCK        5'h11
`define FN_LAST_FIXED       5'h06

// fixed pin bases: serial port on pin 4, second spi on pin 8 (P1.0)
`define SER_PIN_BASE        4
`define SECOND_SPI_PORT_PIN_BASE       8

`endif

// file: verilog/crossbar_alloc.v
// combinational priority allocator: function code per pin
`timescale 1ns/1ns
`include "crossbar_consts.vh"

module crossbar_alloc (
    input  wire [`NUM_FUNCS-1:0]           req_in,      // requested functions by code
    input  wire [`NUM_PINS-1:0]            skip_in,     // per-pin skip bits
    output reg  [`NUM_PINS*`FUNC_W-1:0]    pin_func_out // function code per pin
);

    reg [`NUM_PINS-1:0] taken;  // pins already claimed
    reg                 found;  // current function placed
    integer             f;      // function index
    integer             p;      // pin index

    // fixed pin of a fixed-location function code
    function integer fixed_pin;
        input integer code;
        begin
            if (code <= 2)
                fixed_pin = `SER_PIN_BASE + code - 1;
            else
                fixed_pin = `SECOND_SPI_PORT_PIN_BASE + code - 3;
        end
    endfunction

    // fixed functions first, then flexible ones in priority order
    always @*
    begin
        taken        = {`NUM_PINS{1'b0}};
        pin_func_out = {(`NUM_PINS*`FUNC_W){1'b0}};
        found        = 1'b0;
        for (f = 1; f <= `FN_LAST_FIXED; f = f + 1)
        begin
            if (req_in[f])
            begin
                pin_func_out[fixed_pin(f)*`FUNC_W +: `FUNC_W] = f[`FUNC_W-1:0];
                taken[fixed_pin(f)] = 1'b1;
            end
        end
        for (f = `FN_LAST_FIXED + 1; f < `NUM_FUNCS; f = f + 1)
        begin
            found = 1'b0;
            if (req_in[f])
            begin
                for (p = 0; p < `NUM_PINS; p = p + 1)
                begin
                    if (!found && !skip_in[p] && !taken[p])
                    begin
                        pin_func_out[p*`FUNC_W +: `FUNC_W] = f[`FUNC_W-1:0];
                        taken[p] = 1'b1;
                        found    = 1'b1;
                    end
                end
            end
        end
    end

endmodule // crossbar_alloc

// file: verification/periph_pad_model.sv
// peripheral and pad model standing on the far side of the crossbar
`timescale 1ns/1ns
module periph_pad_model (
    input  wire [4:0]  code_in,          // function whose output is high, 0 = all high
    input  wire [14:0] ext_low_in,       // pins pulled low from outside
    input  wire [14:0] pad_out_in,       // pad values from the block
    input  wire [14:0] pad_oe_in,        // pad enables from the block
    output wire [17:0] periph_out_out,   // peripheral output values by code
    output wire [17:0] periph_drive_out, // every peripheral asks to drive
    output wire [14:0] pad_level_out     // resolved pad levels
);
    // one-hot values let each function's pin show alone on the pads
    assign periph_out_out   = (code_in == 5'h00) ? 18'h3_FFFF : (18'h0_0001 << code_in);
    assign periph_drive_out = 18'h3_FFFF;
    // no analog pins
    // undriven pads rest at the weak pull-up, an outside pull-down always wins
    assign pad_level_out = ~ext_low_in & ((pad_oe_in & pad_out_in) | ~pad_oe_in);
endmodule // periph_pad_model

// file: verification/priority_crossbar_pin_assigner_asserts.sv
// assertions on the crossbar's register and pad ports
`timescale 1ns/1ns
module crossbar_checker (
    input wire logic        clk_in,                   // system clock
    input wire logic        srst_in,                  // synchronous reset
    input wire logic [7:0]  sfr_addr_in,              // register address
    input wire logic [7:0]  sfr_wdata_in,             // write data
    input wire logic        sfr_wr_in,                // write strobe
    input wire logic        sfr_rd_in,                // read strobe
    input wire logic [7:0]  sfr_rdata_out,            // read data
    input wire logic [14:0] pin_output_drive_type_in, // 1 push-pull
    input wire logic [14:0] pad_in,                   // pad levels
    input wire logic [14:0] pad_out,                  // pad values
    input wire logic [14:0] pad_oe_out,               // pad enables
    input wire logic [14:0] pin_level_out,            // synced levels
    input wire logic [17:0] periph_in_out             // levels routed to functions
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic [1:0] up_cnt; // edges since reset, saturates at 3
    // the synchronizer holds reset zeros until three edges have filled it
    always @(posedge clk_in)
        if (srst_in)
            up_cnt <= 2'd0;
        else if (up_cnt != 2'd3)
            up_cnt <= up_cnt + 2'd1;
    sequence s_sel0_write;
        sfr_wr_in && sfr_addr_in == 8'hE1;
    endsequence
    sequence s_sel0_read;
        sfr_rd_in && !sfr_wr_in && sfr_addr_in == 8'hE1;
    endsequence
    a_sel0_readback: assert property (s_sel0_write ##2 s_sel0_read
        |=> sfr_rdata_out == $past(sfr_wdata_in, 3)) else $error("select readback wrong");
    a_unmapped_zero: assert property (sfr_rd_in && sfr_addr_in[7:5] == 3'b100
        |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data moved without a read");
    a_off_no_drive: assert property (sfr_wr_in && sfr_addr_in == 8'hE3 && !sfr_wdata_in[6]
        |-> ##2 pad_oe_out == 15'h0000) else $error("drivers on while crossbar off");
    a_sync_latency: assert property (up_cnt == 2'd3 |-> pin_level_out == $past(pad_in, 3))
        else $error("pin level not three cycles behind pad");
    a_open_drain_low: assert property ((pad_oe_out & pad_out & ~$past(pin_output_drive_type_in))
        == 15'h0000) else $error("open-drain pin driven high");
    a_serial_unrouted: assert property (sfr_wr_in && sfr_addr_in == 8'hE1 && !sfr_wdata_in[0]
        |-> ##2 periph_in_out[2]) else $error("receive routed while serial off");
    a_first_spi_port_unrouted: assert property (sfr_wr_in && sfr_addr_in == 8'hE1 && !sfr_wdata_in[1]
        |-> ##2 periph_in_out[10:7] == 4'hF) else $error("first spi routed while off");
    a_second_spi_port_unrouted: assert property (sfr_wr_in && sfr_addr_in == 8'hE2 && !sfr_wdata_in[6]
        |=> ##1 periph_in_out[6:3] == 4'hF) else $error("second spi routed while off");
endmodule // crossbar_checker
bind priority_crossbar_pin_assigner crossbar_checker i_crossbar_checker (
    .clk_in(clk_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .pin_output_drive_type_in(pin_output_drive_type_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pin_level_out(pin_level_out), .periph_in_out(periph_in_out));

// file: verification/priority_crossbar_pin_assigner_tb.sv
// self-checking bench for the priority crossbar pin assigner
`timescale 1ns/1ns
module priority_crossbar_pin_assigner_tb;
    logic        clk_in = 1'b0; // 50 MHz clock
    logic        srst_in = 1'b1; // synchronous reset
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv; // bus address, data
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0; // bus strobes
    logic [1:0]  first_spi_port_mode = 2'b00, second_spi_port_mode = 2'b00; // spi select modes
    logic [14:0] drive_type = 15'h7FFF, latch = 15'h0000, ext_low = 15'h0000; // pad setup
    logic [4:0]  code = 5'h00; // function shown on the pads
    logic [17:0] periph_out, periph_drive, periph_in; // peripheral side
    logic [14:0] pad_level, pad_out, pad_oe, pin_level, exp_used; // pad side
    int          exp_pin [18]; // expected pin per code, -1 when dropped
    int          mismatches = 0, total_checks = 0, cycles = 0; // counters
    // configs: select_0, second spi on, skip bits, first and second spi 4-wire
    logic [7:0]  cfg_s0 [6] = '{8'hFF, 8'hFE, 8'hFE, 8'h0F, 8'h81, 8'hF8};
    logic        cfg_e1 [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [14:0] cfg_sk [6] = '{15'h0000, 15'h000C, 15'h000C, 15'h00F3, 15'h7CCF, 15'h5555};
    logic        cfg_w0 [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic        cfg_w1 [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    priority_crossbar_pin_assigner i_priority_crossbar_pin_assigner (
        .clk_in(clk_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr),
        .sfr_wdata_in(sfr_wdata), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
        .sfr_rdata_out(sfr_rdata), .spi_select_mode_field_in(first_spi_port_mode),
        .second_spi_mode_in(second_spi_port_mode), .pin_output_drive_type_in(drive_type),
        .port_latch_in(latch), .periph_out_in(periph_out), .periph_drive_in(periph_drive),
        .pad_in(pad_level), .pad_out(pad_out), .pad_oe_out(pad_oe),
        .pin_level_out(pin_level), .periph_in_out(periph_in));
    periph_pad_model i_periph_pad_model (
        .code_in(code), .ext_low_in(ext_low), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
        .periph_out_out(periph_out), .periph_drive_out(periph_drive),
        .pad_level_out(pad_level));
    initial
    begin
        forever #10 clk_in = ~clk_in;
    end
    // a hang ends the run as a mismatch
    always @(posedge clk_in)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one write, strobe held across exactly one rising edge, then one idle
    // edge so the next call never raises a strobe in the step that lowered it
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_in);
        sfr_wr = 1'b0;
        @(negedge clk_in);
    endtask
    // read data is settled by the falling edge after the read edge
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_in);
        sfr_rd = 1'b0;
        d = sfr_rdata;
        @(negedge clk_in);
    endtask
    // reference allocation: fixed pins first, then lowest free unskipped pin
    task automatic plan(input int c);
        int  p;
        logic want;
        p = 0;
        exp_used = 15'h0000;
        foreach (exp_pin[f]) exp_pin[f] = -1;
        for (int f = 1; f < 7; f++)
        begin
            want = f < 3 ? cfg_s0[c][0] : cfg_e1[c] && (f < 6 || cfg_w1[c]);
            if (want)
                exp_pin[f] = f < 3 ? f + 3 : f + 5;
            if (want)
                exp_used[exp_pin[f]] = 1'b1;
        end
        for (int f = 7; f < 18; f++)
        begin
            want = f < 11 ? cfg_s0[c][1] && (f < 10 || cfg_w0[c]) : f < 13 ? cfg_s0[c][2]
                 : f == 17 ? cfg_s0[c][3] : cfg_s0[c][f - 9];
            while (p < 15 && (exp_used[p] || cfg_sk[c][p])) p++;
            if (want && p < 15)
                exp_pin[f] = p;
            if (want && p < 15)
                exp_used[p] = 1'b1;
        end
    endtask
    initial
    begin
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        bus_read(8'hE1, rv);
        check(18'(rv), 18'h0_0000);
        bus_write(8'hE1, 8'hA5);
        bus_read(8'hE1, rv);
        check(18'(rv), 18'h0_00A5);
        bus_write(8'hE2, 8'hFF);
        bus_read(8'hE2, rv);
        check(18'(rv), 18'h0_0040);
        bus_write(8'hE3, 8'hFF);
        bus_read(8'hE3, rv);
        check(18'(rv), 18'h0_00C0);
        bus_read(8'h80, rv);
        check(18'(rv), 18'h0_0000);
        bus_write(8'hE3, 8'h40);
        for (int c = 0; c < 6; c++)
        begin
            // 4-wire uses code 11 for the first spi and 10 for the second, so encoding 01 is never driven
            first_spi_port_mode = {cfg_w0[c], cfg_w0[c]};
            second_spi_port_mode = {cfg_w1[c], 1'b0};
            bus_write(8'hE1, cfg_s0[c]);
            bus_write(8'hE2, {1'b0, cfg_e1[c], 6'h00});
            bus_write(8'hD4, cfg_sk[c][7:0]);
            bus_write(8'hD5, {1'b0, cfg_sk[c][14:8]});
            plan(c);
            repeat (2) @(negedge clk_in);
            bus_read(8'hD6, rv);
            check(18'(rv), 18'(exp_used[7:0]));
            bus_read(8'hD7, rv);
            check(18'(rv), 18'(exp_used[14:8]));
            for (int f = 1; f < 18; f++)
            begin
                code = 5'(f);
                repeat (2) @(negedge clk_in);
                check(18'(pad_out), exp_pin[f] < 0 ? 18'h0 : 18'(1 << exp_pin[f]));
                if (f > 10 && f < 13 && exp_pin[f] >= 0)
                    check(18'(pad_oe[exp_pin[f]]), 18'h0_0000);
            end
        end
        bus_write(8'hE3, 8'h00);
        repeat (2) @(negedge clk_in);
        check(18'(pad_oe), 18'h0_0000);
        // open-drain high everywhere so the outside pattern reaches the pads
        bus_write(8'hE3, 8'h40);
        bus_write(8'hE2, 8'h00);
        bus_write(8'hE1, 8'h01);
        drive_type = 15'h0000;
        latch = 15'h7FFF;
        code = 5'h00;
        ext_low = 15'h2A3C;
        repeat (6) @(negedge clk_in);
        check(18'(pin_level), {3'b000, ~ext_low});
        check(18'(periph_in[2]), 18'(!ext_low[5]));
        check(18'(periph_in[7]), 18'h0_0001);
        final_report;
    end
endmodule // priority_crossbar_pin_assigner_tb
